// ---- tb_vipa_ctrl.sv ----
// Self-checking bench for the interrupt acknowledge control
`timescale 1ns/10ps
module tb_vipa_ctrl;
    import vipa_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] addr = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic wide = 1'b0;
    logic bitop = 1'b0;
    logic [2:0] bidx = '0;
    logic [15:0] wdat = '0;
    logic [7:0] psd = '0;
    logic [3:0] pf = '0;
    logic [NUM_SRC-1:0] rq = '0;
    logic [NUM_SRC-1:0] rc = '0;
    logic [NUM_SRC-1:0] mk = '1;
    logic [2:0] pin = '0;
    logic [NUM_SRC-1:0] flags;
    logic [15:0] rdat, pc, pd, vec;
    logic [7:0] program_status_word;
    logic hit, bnd, break_instruction, busy, pv, pl;
    int n_mismatch = 0;
    int samples_checked = 0;
    int lat;
    always #25 clk = ~clk;
    vipa_ctrl uut (.core_clk_in(clk), .reset_n_in(rst_n),
        .mem_addr_in(addr), .mem_wr_in(wr), .mem_rd_in(rd),
        .mem_wide_in(wide), .mem_bit_in(bitop), .mem_bit_idx_in(bidx),
        .mem_wdata_in(wdat), .mem_rdata_out(rdat), .mem_hit_out(hit),
        .psw_wr_in(pf[3]), .psw_wdata_in(psd), .psw_restore_in(pf[2]),
        .psw_restore_data_in(psd), .enable_int_instruction_in(pf[0]),
        .disable_int_instruction_in(pf[1]), .psw_out(program_status_word),
        .req_pulse_in(rq), .req_clr_in(rc), .mask_flags_in(mk),
        .port3_bit0_in(pin[0]), .port3_bit3_in(pin[1]),
        .comparator_in(pin[2]), .req_flags_out(flags),
        .instr_boundary_in(bnd), .break_instruction_in(break_instruction), .pc_in(pc),
        .busy_out(busy), .push_valid_out(pv), .push_data_out(pd),
        .pc_load_out(pl), .pc_vector_out(vec));
    vipa_cpu_model cpu (.core_clk_in(clk), .push_valid_in(pv),
        .push_data_in(pd), .pc_load_in(pl), .boundary_out(bnd),
        .break_out(break_instruction), .pc_out(pc));
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [15:0] d, input logic wd,
                       input logic b, input logic [2:0] i);
        tick();
        addr = a;
        wr = w;
        rd = !w;
        wdat = d;
        wide = wd;
        bitop = b;
        bidx = i;
        tick();
        wr = 1'b0;
        rd = 1'b0;
    endtask
    task automatic rdck(input logic [15:0] a, input logic wd,
                        input logic [15:0] e, input logic h);
        acc(1'b0, a, 16'h0000, wd, 1'b0, 3'd0);
        chk("rdata", e, rdat);
        chk("hit", {15'h0000, h}, {15'h0000, hit});
    endtask
    task automatic pulse(input logic [NUM_SRC-1:0] r,
                         input logic [NUM_SRC-1:0] c, input logic [3:0] f);
        tick();
        rq = r;
        rc = c;
        pf = f;
        tick();
        rq = '0;
        rc = '0;
        pf = '0;
    endtask
    task automatic ack(input logic b, input logic [15:0] p, input int el,
                       input logic [15:0] p0, input logic [15:0] v);
        cpu.step(b, p, lat);
        chk("latency", 16'(el), 16'(lat));
        if (el < 8)
        begin
            chk("push psw", p0, cpu.pushed[0]);
            chk("push pc", p, cpu.pushed[1]);
            chk("vector", v, vec);
            chk("busy", 16'h0001, {15'h0000, busy});
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #60000;
        n_mismatch++;
        stop_test();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (3) tick();
        chk("psw", 16'(PSW_RESET), {8'h00, program_status_word});
        rdck(ADDR_PR0_LOW, 1'b1, 16'hffff, 1'b1);
        rdck(ADDR_PR1_LOW, 1'b0, 16'h00ff, 1'b1);
        rdck(ADDR_RISE_EN, 1'b0, 16'h0000, 1'b1);
        rdck(ADDR_FALL_EN, 1'b0, 16'h0000, 1'b1);
        rdck(16'hff00, 1'b0, 16'h0000, 1'b0);
        $display("test reset values done");
        acc(1'b1, ADDR_PR0_LOW, 16'hfffe, 1'b1, 1'b0, 3'd0);
        acc(1'b1, ADDR_PR0_LOW, 16'h0000, 1'b0, 1'b1, 3'd1);
        rdck(ADDR_PR0_LOW, 1'b1, 16'hfffc, 1'b1);
        acc(1'b1, ADDR_PR0_HIGH, 16'h003e, 1'b0, 1'b0, 3'd0);
        rdck(ADDR_PR0_LOW, 1'b1, 16'h3efc, 1'b1);
        acc(1'b1, ADDR_RISE_EN, 16'h0005, 1'b0, 1'b0, 3'd0);
        acc(1'b1, ADDR_FALL_EN, 16'h0006, 1'b0, 1'b0, 3'd0);
        rdck(ADDR_FALL_EN, 1'b0, 16'h0006, 1'b1);
        pin = 3'b111;
        repeat (6) tick();
        chk("rise flags", 16'h000a, flags[15:0]);
        pulse('0, '1, 4'd0);
        pin = 3'b000;
        repeat (6) tick();
        chk("fall flags", 16'h000c, flags[15:0]);
        pulse('0, '1, 4'd0);
        acc(1'b1, ADDR_RISE_EN, 16'h0000, 1'b0, 1'b0, 3'd0);
        acc(1'b1, ADDR_FALL_EN, 16'h0000, 1'b0, 1'b0, 3'd0);
        pin = 3'b111;
        repeat (6) tick();
        chk("off flags", 16'h0000, flags[15:0]);
        $display("test registers and edges done");
        pulse('0, '0, 4'b0001);
        chk("psw ei", 16'h0082, {8'h00, program_status_word});
        pulse('0, '0, 4'b0010);
        chk("psw di", 16'h0002, {8'h00, program_status_word});
        psd = 8'h82;
        pulse('0, '0, 4'b1000);
        chk("psw wr", 16'h0082, {8'h00, program_status_word});
        mk[8] = 1'b0;
        pulse(NUM_SRC'(1) << 8, '0, 4'd0);
        ack(1'b0, 16'h1234, 3, 16'h0082, 16'h0014);
        chk("psw ack", 16'h0000, {8'h00, program_status_word});
        chk("flag clear", 16'h0000, flags[15:0]);
        $display("test high ack done");
        mk[16] = 1'b0;
        pulse(NUM_SRC'(1) << 16, '0, 4'd0);
        ack(1'b0, 16'h2222, 8, 16'h0000, 16'h0000);
        pulse('0, '0, 4'b0001);
        ack(1'b0, 16'h2222, 8, 16'h0000, 16'h0000);
        pulse('0, '0, 4'b0100);
        ack(1'b0, 16'h3456, 4, 16'h0082, 16'h0024);
        chk("psw low", 16'h0002, {8'h00, program_status_word});
        $display("test pending low done");
        mk[15:9] = 7'b0010100;
        pulse('0, '0, 4'b0001);
        pulse(24'h008a00, '0, 4'd0);
        ack(1'b0, 16'h4444, 3, 16'h0082, 16'h0022);
        pulse('0, '0, 4'b0001);
        pulse(24'h00c000, '0, 4'd0);
        ack(1'b0, 16'h5555, 3, 16'h0080, 16'h0020);
        chk("pending", 16'h8a00, flags[15:0]);
        $display("test priority done");
        ack(1'b1, 16'h6666, 3, 16'h0000, VEC_BREAK);
        chk("psw brk", 16'h0000, {8'h00, program_status_word});
        psd = 8'h82;
        pulse('0, '0, 4'b0100);
        chk("psw break_return", 16'h0082, {8'h00, program_status_word});
        $display("test break done");
        stop_test();
    end
endmodule

// ---- vipa_cpu_model.sv ----
// CPU core model: instruction boundaries and push capture
`timescale 1ns/10ps
module vipa_cpu_model (
    // Clock
    input wire logic core_clk_in,
    // Sequencer results
    input wire logic push_valid_in,
    input wire logic [15:0] push_data_in,
    input wire logic pc_load_in,
    // Instruction boundary
    output logic boundary_out,
    output logic break_out,
    output logic [15:0] pc_out
);
    logic [15:0] pushed [0:1];
    logic [1:0] n_push;
    initial
    begin
        boundary_out = 1'b0;
        break_out = 1'b0;
        pc_out = 16'h0000;
        n_push = 2'd0;
    end
    always @(posedge core_clk_in)
    begin
        if (boundary_out)
            n_push <= 2'd0;
        else if (push_valid_in)
        begin
            pushed[n_push[0]] <= push_data_in;
            n_push <= n_push + 2'd1;
        end
    end
    // One completing instruction, then stall until the vector load or until lat reaches 8 clocks
    task automatic step(input logic b, input logic [15:0] p,
                        output int lat);
        @(posedge core_clk_in);
        #1;
        boundary_out = 1'b1;
        break_out = b;
        pc_out = p;
        @(posedge core_clk_in);
        #1;
        boundary_out = 1'b0;
        break_out = 1'b0;
        pc_out = ~p;
        lat = 1;
        while (pc_load_in !== 1'b1 && lat < 8)
        begin
            @(posedge core_clk_in);
            #1;
            lat++;
        end
    endtask
endmodule

// ---- vipa_ctrl.sv ----
// Interrupt priority, acknowledge and vectoring control
`timescale 1ns/10ps
module vipa_ctrl (
    // Clock and reset
    input logic core_clk_in,
    input logic reset_n_in,
    // CPU memory access
    input logic [15:0] mem_addr_in,
    input logic mem_wr_in,
    input logic mem_rd_in,
    input logic mem_wide_in,
    input logic mem_bit_in,
    input logic [2:0] mem_bit_idx_in,
    input logic [15:0] mem_wdata_in,
    output logic [15:0] mem_rdata_out,
    output logic mem_hit_out,
    // Status word access
    input logic psw_wr_in,
    input logic [7:0] psw_wdata_in,
    input logic psw_restore_in,
    input logic [7:0] psw_restore_data_in,
    input logic enable_int_instruction_in,
    input logic disable_int_instruction_in,
    output logic [7:0] psw_out,
    // Interrupt sources
    input logic [vipa_pkg::NUM_SRC-1:0] req_pulse_in,
    input logic [vipa_pkg::NUM_SRC-1:0] req_clr_in,
    input logic [vipa_pkg::NUM_SRC-1:0] mask_flags_in,
    input logic port3_bit0_in,
    input logic port3_bit3_in,
    input logic comparator_in,
    output logic [vipa_pkg::NUM_SRC-1:0] req_flags_out,
    // CPU sequencing
    input logic instr_boundary_in,
    input logic break_instruction_in,
    input logic [15:0] pc_in,
    output logic busy_out,
    output logic push_valid_out,
    output logic [15:0] push_data_out,
    output logic pc_load_out,
    output logic [15:0] pc_vector_out
);
    import vipa_pkg::*;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    function automatic logic [7:0] apply_wr(input logic [7:0] old,
                                           input logic [7:0] data,
                                           input logic bit_op,
                                           input logic [2:0] idx);
        logic [7:0] res;
        res = old;
        if (bit_op)
            res[idx] = data[0];
        else
            res = data;
        return res;
    endfunction

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] priority_flags_0_low_q, priority_flags_0_low_d, priority_flags_0_high_q, priority_flags_0_high_d, priority_flags_1_low_q, priority_flags_1_low_d;
    logic [EDGE_BITS-1:0] rise_q, rise_d, fall_q, fall_d;
    logic [15:0] rdata_q, rdata_d;
    logic hit_q, hit_d;
    logic wide_pr0;
    logic [7:0] wlo;
    logic [7:0] rise_wr;
    logic [7:0] fall_wr;

    assign wide_pr0 = mem_wide_in && !mem_bit_in
                   && mem_addr_in == ADDR_PR0_LOW;
    assign wlo = mem_wdata_in[7:0];
    assign rise_wr = apply_wr({5'h00, rise_q}, wlo, mem_bit_in,
                              mem_bit_idx_in);
    assign fall_wr = apply_wr({5'h00, fall_q}, wlo, mem_bit_in,
                              mem_bit_idx_in);

    always_comb
    begin
        priority_flags_0_low_d = priority_flags_0_low_q;
        priority_flags_0_high_d = priority_flags_0_high_q;
        priority_flags_1_low_d = priority_flags_1_low_q;
        rise_d = rise_q;
        fall_d = fall_q;
        if (mem_wr_in)
        begin
            if (wide_pr0)
            begin
                priority_flags_0_low_d = mem_wdata_in[7:0]; // R05
                priority_flags_0_high_d = mem_wdata_in[15:8]; // R05
            end
            else
            begin
                case (mem_addr_in)
                    ADDR_PR0_LOW:
                        priority_flags_0_low_d = apply_wr(priority_flags_0_low_q, wlo, mem_bit_in,
                                          mem_bit_idx_in); // R03
                    ADDR_PR0_HIGH:
                        priority_flags_0_high_d = apply_wr(priority_flags_0_high_q, wlo, mem_bit_in,
                                          mem_bit_idx_in); // R03
                    ADDR_PR1_LOW:
                        priority_flags_1_low_d = apply_wr(priority_flags_1_low_q, wlo, mem_bit_in,
                                          mem_bit_idx_in); // R03
                    ADDR_RISE_EN:
                        rise_d = rise_wr[EDGE_BITS-1:0];
                    ADDR_FALL_EN:
                        fall_d = fall_wr[EDGE_BITS-1:0];
                    default:
                        ;
                endcase
            end
        end
        rdata_d = 16'h0000;
        hit_d = 1'b0;
        if (mem_rd_in)
        begin
            hit_d = 1'b1;
            if (mem_wide_in && mem_addr_in == ADDR_PR0_LOW)
                rdata_d = {priority_flags_0_high_q, priority_flags_0_low_q}; // R05
            else
            begin
                case (mem_addr_in)
                    ADDR_PR0_LOW: rdata_d = {8'h00, priority_flags_0_low_q};
                    ADDR_PR0_HIGH: rdata_d = {8'h00, priority_flags_0_high_q};
                    ADDR_PR1_LOW: rdata_d = {8'h00, priority_flags_1_low_q};
                    ADDR_RISE_EN: rdata_d = {13'h0000, rise_q};
                    ADDR_FALL_EN: rdata_d = {13'h0000, fall_q};
                    default: hit_d = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            priority_flags_0_low_q <= PR_RESET; // R03
            priority_flags_0_high_q <= PR_RESET;
            priority_flags_1_low_q <= PR_RESET;
            rise_q <= EDGE_RESET[EDGE_BITS-1:0]; // R07
            fall_q <= EDGE_RESET[EDGE_BITS-1:0]; // R07
            rdata_q <= 16'h0000;
            hit_q <= 1'b0;
        end
        else
        begin
            priority_flags_0_low_q <= priority_flags_0_low_d;
            priority_flags_0_high_q <= priority_flags_0_high_d;
            priority_flags_1_low_q <= priority_flags_1_low_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
            rdata_q <= rdata_d;
            hit_q <= hit_d;
        end
    end

    // ------------------------------------------------------------------
    // External edges and request flags
    // ------------------------------------------------------------------
    logic [EDGE_BITS-1:0] ext_edge;
    logic [NUM_SRC-1:0] set_vec;
    logic [NUM_SRC-1:0] ack_clr;
    logic [NUM_SRC-1:0] req_q, req_d;

    vipa_edge_det u_edge (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_q),
        .pin_in({comparator_in, port3_bit3_in, port3_bit0_in}), // R09
        .rise_en_in(rise_q),
        .fall_en_in(fall_q),
        .edge_out(ext_edge)
    );

    always_comb
    begin
        set_vec = req_pulse_in;
        set_vec[SRC_EXT0] = req_pulse_in[SRC_EXT0] | ext_edge[0]; // R09
        set_vec[SRC_EXT1] = req_pulse_in[SRC_EXT1] | ext_edge[1]; // R09
        set_vec[SRC_CMP] = req_pulse_in[SRC_CMP] | ext_edge[2]; // R09
        // Pending flags hold until taken; a new event beats any clear
        req_d = (req_q & ~(req_clr_in | ack_clr)) | set_vec; // R17 R23
    end

    always_ff @(posedge core_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
            req_q <= '0;
        else
            req_q <= req_d;
    end

    // ------------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------------
    logic [7:0] psw_q, psw_d;
    logic [NUM_SRC-1:0] pr_all, elig, elig_hi, elig_lo;
    logic win_found;
    logic win_pr;
    logic [SRC_W-1:0] win_idx;

    assign pr_all = {priority_flags_1_low_q, priority_flags_0_high_q, priority_flags_0_low_q}; // R02
    assign elig = req_q & ~mask_flags_in; // R01 R13
    assign elig_hi = elig & ~pr_all;
    assign elig_lo = elig & pr_all & {NUM_SRC{psw_q[PSW_ISP_BIT]}}; // R14

    always_comb
    begin
        win_found = 1'b0;
        win_pr = 1'b0;
        win_idx = '0;
        // Lowest index wins within a level; high level searched first
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (elig_hi[i])
            begin
                win_found = 1'b1; // R16 R24
                win_idx = SRC_W'(i);
            end
        end
        if (!win_found)
        begin
            for (int i = NUM_SRC - 1; i >= 0; i--)
            begin
                if (elig_lo[i])
                begin
                    win_found = 1'b1; // R16 R24
                    win_pr = 1'b1;
                    win_idx = SRC_W'(i);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Acknowledge sequencer and status word
    // ------------------------------------------------------------------
    vipa_state_t state_q, state_d;
    logic ack_brk, ack_mask, ack_any;
    logic [7:0] spsw_q, spsw_d;
    logic [15:0] spc_q, spc_d, vec_q, vec_d, pdata_q, pdata_d;
    logic [SRC_W-1:0] sidx_q, sidx_d;
    logic busy_q, busy_d, push_q, push_d, load_q, load_d;

    assign ack_brk = state_q == ST_IDLE && instr_boundary_in
                  && break_instruction_in; // R20 R25
    assign ack_mask = state_q == ST_IDLE && instr_boundary_in
                   && !break_instruction_in && psw_q[PSW_IE_BIT]
                   && win_found; // R14 R25
    assign ack_any = ack_brk || ack_mask;
    assign ack_clr = ack_mask ? (NUM_SRC'(1) << win_idx) : '0; // R23

    always_comb
    begin
        state_d = state_q;
        spsw_d = spsw_q;
        spc_d = spc_q;
        vec_d = vec_q;
        sidx_d = sidx_q;
        psw_d = psw_q;
        case (state_q)
            ST_IDLE:
            begin
                if (ack_any)
                begin
                    spsw_d = psw_q;
                    spc_d = pc_in;
                    psw_d[PSW_IE_BIT] = 1'b0; // R18 R21
                    if (ack_brk)
                    begin
                        vec_d = VEC_BREAK; // R21
                        state_d = ST_PUSH_PSW;
                    end
                    else
                    begin
                        psw_d[PSW_ISP_BIT] = win_pr; // R18
                        sidx_d = win_idx;
                        vec_d = VEC_BASE + {10'h000, win_idx, 1'b0}; // R18
                        state_d = win_pr ? ST_WAIT_LOW : ST_PUSH_PSW; // R15
                    end
                end
                else if (psw_restore_in)
                    psw_d = psw_restore_data_in; // R19
                else if (psw_wr_in)
                    psw_d = psw_wdata_in; // R12
                else if (enable_int_instruction_in)
                    psw_d[PSW_IE_BIT] = 1'b1; // R12
                else if (disable_int_instruction_in)
                    psw_d[PSW_IE_BIT] = 1'b0; // R12
            end
            ST_WAIT_LOW: state_d = ST_PUSH_PSW;
            ST_PUSH_PSW: state_d = ST_PUSH_PC;
            ST_PUSH_PC: state_d = ST_VECTOR;
            ST_VECTOR: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
        busy_d = state_d != ST_IDLE;
        push_d = state_d == ST_PUSH_PSW || state_d == ST_PUSH_PC; // R18
        pdata_d = state_d == ST_PUSH_PSW ? {8'h00, spsw_d} : spc_d; // R18
        load_d = state_d == ST_VECTOR;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= ST_IDLE;
            psw_q <= PSW_RESET; // R11
            spsw_q <= 8'h00;
            spc_q <= 16'h0000;
            vec_q <= 16'h0000;
            sidx_q <= '0;
            busy_q <= 1'b0;
            push_q <= 1'b0;
            pdata_q <= 16'h0000;
            load_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            psw_q <= psw_d;
            spsw_q <= spsw_d;
            spc_q <= spc_d;
            vec_q <= vec_d;
            sidx_q <= sidx_d;
            busy_q <= busy_d;
            push_q <= push_d;
            pdata_q <= pdata_d;
            load_q <= load_d;
        end
    end

    assign mem_rdata_out = rdata_q;
    assign mem_hit_out = hit_q;
    assign psw_out = psw_q;
    assign req_flags_out = req_q;
    assign busy_out = busy_q;
    assign push_valid_out = push_q;
    assign push_data_out = pdata_q;
    assign pc_load_out = load_q;
    assign pc_vector_out = vec_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_q);

    AST_ACK_NEEDS_ELIG: assert property (ack_mask |-> // R13
        req_q[win_idx] && !mask_flags_in[win_idx])
        else $error("acknowledged source not eligible");
    AST_LOW_BLOCKED: assert property (ack_mask && win_pr |-> // R14
        psw_q[PSW_ISP_BIT] && elig_hi == '0)
        else $error("low level taken while blocked");
    AST_ACK_CLEARS_IE: assert property (ack_any |=> // R18
        !psw_q[PSW_IE_BIT] && busy_out)
        else $error("enable not cleared on acknowledge");
    AST_ISP_COPY: assert property (ack_mask |=> // R18
        psw_q[PSW_ISP_BIT] == $past(win_pr))
        else $error("in-service flag not copied");
    AST_REQ_CLEARED: assert property (ack_mask && !set_vec[win_idx] // R23
        |=> !req_q[sidx_q])
        else $error("request flag not cleared");
    AST_HI_SEQ: assert property (ack_mask && !win_pr |-> // R15
        ##1 (push_valid_out && push_data_out[7:0] == $past(psw_q))
        ##1 push_valid_out ##1 (pc_load_out && !push_valid_out))
        else $error("high level stacking sequence wrong");
    AST_LO_SEQ: assert property (ack_mask && win_pr |-> // R15
        ##1 !push_valid_out ##1 push_valid_out ##1 push_valid_out
        ##1 pc_load_out)
        else $error("low level sequence lacks extra clock");
    AST_BRK_VEC: assert property (ack_brk |-> ##3 // R21
        (pc_load_out && pc_vector_out == VEC_BREAK))
        else $error("break vector wrong");
    AST_BRK_ALWAYS: assert property (state_q == ST_IDLE // R20
        && instr_boundary_in && break_instruction_in |=>
        push_valid_out && !psw_q[PSW_IE_BIT] && busy_out)
        else $error("break not taken");
    AST_DEF_PRIO: assert property (ack_mask |-> // R16
        ((win_pr ? elig_lo : elig_hi) & ((NUM_SRC'(1) << win_idx) - 1))
        == '0)
        else $error("lower default priority source won");

    COV_HI_ACK: cover property (ack_mask && !win_pr ##3 pc_load_out);
    COV_LO_ACK: cover property (ack_mask && win_pr ##4 pc_load_out);
    COV_BRK: cover property (ack_brk && win_found);
    COV_PENDING: cover property (!psw_q[PSW_IE_BIT] && win_found
        ##1 ack_mask);

endmodule

// ---- vipa_edge_det.sv ----
// External interrupt pin synchroniser and valid-edge detector
`timescale 1ns/10ps
module vipa_edge_det (
    // Clock and reset
    input logic core_clk_in,
    input logic rst_n_in,
    // Pins and edge selection
    input logic [vipa_pkg::EDGE_BITS-1:0] pin_in,
    input logic [vipa_pkg::EDGE_BITS-1:0] rise_en_in,
    input logic [vipa_pkg::EDGE_BITS-1:0] fall_en_in,
    // Detected edges
    output logic [vipa_pkg::EDGE_BITS-1:0] edge_out
);
    import vipa_pkg::*;

    logic [EDGE_BITS-1:0] meta_q;
    logic [EDGE_BITS-1:0] sync_q;
    logic [EDGE_BITS-1:0] prev_q;
    logic [EDGE_BITS-1:0] edge_q;
    logic [EDGE_BITS-1:0] edge_d;

    always_comb
    begin
        edge_d = (sync_q & ~prev_q & rise_en_in)
               | (~sync_q & prev_q & fall_en_in); // R06
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
            edge_q <= '0;
        end
        else
        begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
            edge_q <= edge_d;
        end
    end

    assign edge_out = edge_q;

    AST_EDGE_OFF: assert property (@(posedge core_clk_in) disable iff // R06
        (!rst_n_in) (rise_en_in == '0 && fall_en_in == '0) |=> edge_q == '0)
        else $error("edge reported while detection disabled");

endmodule

// ---- vipa_pkg.sv ----
// Constants shared by the vectored interrupt priority/acknowledge block
// Function
// R01: Mask flag 0 lets its source be serviced, 1 blocks it.
// R02: Priority flag 0 selects high level, 1 selects low level.
// R03: Three priority registers reset to all ones; bit or byte writable.
// R04: Software writes ones into unused priority register bits.
// R05: Low and high priority registers also form one 16-bit register.
// R06: Edge enable pair: 00 off, 01 falling, 10 rising, 11 both.
// R07: Both edge enable registers clear to zero on reset.
// R08: Software keeps edge enable bits 3 to 7 at zero.
// R09: Edge bit 0 is port3_bit0, bit 1 port3_bit3, bit 2 comparator.
// R10: Software clears both edge bits before returning a pin to port use.
// R11: Status word holds enable and in-service flags, resets to 02H.
// R12: Status word byte and bit writable; enable/disable set and clear enable.
// R13: Source eligible only with request flag 1 and mask flag 0.
// R14: Needs global enable; low level blocked while in-service flag is 0.
// R15: Request to vector latency 7-32 clocks high, 8-33 clocks low.
// R16: Higher programmed level wins; ties go to fixed default priority.
// R17: Untaken request stays pending until its conditions are met.
// R18: Ack pushes status then PC, clears enable, copies priority, vectors.
// R19: Status word pushed and restored by the stack instructions.
// R20: Break instruction always raises a software interrupt.
// R21: Software interrupt pushes status, PC, clears enable, vectors to 003EH.
// R22: Software leaves a software interrupt only with break return.
// R23: Accepted source request flag clears automatically on acknowledge.
// R24: Default priority ranks sources from 0 highest to 28 lowest. Code has NUM_SRC = 24 sources, 0 to 23.
// R25: Acknowledge and stacking only at an instruction boundary.
package vipa_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_RISE_EN = 16'hff48;
    localparam logic [15:0] ADDR_FALL_EN = 16'hff49;
    localparam logic [15:0] ADDR_PR0_LOW = 16'hffe8;
    localparam logic [15:0] ADDR_PR0_HIGH = 16'hffe9;
    localparam logic [15:0] ADDR_PR1_LOW = 16'hffea;

    localparam logic [7:0] PR_RESET = 8'hff;
    localparam logic [7:0] EDGE_RESET = 8'h00;
    localparam int EDGE_BITS = 3;
    localparam logic [7:0] PSW_RESET = 8'h02;
    localparam int PSW_IE_BIT = 7;
    localparam int PSW_ISP_BIT = 1;

    // ------------------------------------------------------------------
    // Sources: flag position equals default priority
    // ------------------------------------------------------------------
    localparam int NUM_SRC = 24;
    localparam int SRC_W = 5;
    localparam int SRC_EXT0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_CMP = 3;
    localparam logic [15:0] VEC_BASE = 16'h0004;
    localparam logic [15:0] VEC_BREAK = 16'h003e;
    localparam int LOWEST_DEF_PRIO = 28;

    // ------------------------------------------------------------------
    // Timing in CPU clocks
    // ------------------------------------------------------------------
    localparam int LAT_MIN_HI_CLK = 7;
    localparam int LAT_MAX_HI_CLK = 32;
    localparam int LAT_MIN_LO_CLK = 8;
    localparam int LAT_MAX_LO_CLK = 33;
    localparam int LO_EXTRA_CLK = LAT_MIN_LO_CLK - LAT_MIN_HI_CLK;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_LOW,
        ST_PUSH_PSW,
        ST_PUSH_PC,
        ST_VECTOR
    } vipa_state_t;

endpackage
